// *** dv/console_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module console_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // console
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic cmd_has_arg,
   input wire logic [console_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic enter_key,
   input wire logic func_key,
   input wire logic [2:0] screen_r,
   input wire logic halt_shown_r,
   input wire logic [console_pkg::ADDR_W-1:0] halt_shown_addr_r,
   input wire logic ent_valid_r,
   input wire logic [console_pkg::SLOT_W-1:0] ent_slot_r,
   input wire logic [console_pkg::CODE_W-1:0] load_code_r,
   input wire logic load_ok_r,
   // director
   input wire logic reg_rd_ack,
   input wire logic reg_rd_readable,
   input wire logic dir_step,
   input wire logic [console_pkg::ADDR_W-1:0] dir_addr,
   input wire logic dir_stop_r,
   input wire logic load_start_r,
   input wire logic load_abort_r,
   input wire logic load_done,
   input wire logic [console_pkg::CODE_W-1:0] load_code
);
   logic top;
   logic ext;
   assign top = screen_r == 3'h0;
   assign ext = screen_r inside {3'h1, 3'h2, 3'h3};
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_load_start: assert property (
      cmd_valid && cmd_op == 3'h2 && top |=> load_start_r && screen_r == 3'h7)
      else $error("load not started");
   a_load_end: assert property (
      screen_r == 3'h7 && load_done |=> screen_r == 3'h5 && load_code_r == $past(load_code))
      else $error("completion code not shown");
   a_code_ok: assert property (
      load_ok_r == (load_code_r == console_pkg::LOAD_CODE_OK))
      else $error("normal end flag wrong");
   a_slot_range: assert property (
      ent_valid_r |-> ent_slot_r < console_pkg::PAGE_REGS)
      else $error("slot beyond page");
   a_func_exit: assert property (
      func_key && ext |=> top)
      else $error("function key did not exit");
   a_bad_exit: assert property (
      cmd_valid && cmd_op == 3'h4 && screen_r inside {3'h1, 3'h2} |=> top)
      else $error("invalid subcommand did not exit");
   a_wait_enter: assert property (
      screen_r == 3'h6 && enter_key |=> top)
      else $error("enter did not end wait");
   a_halt_stop: assert property (
      halt_shown_r && dir_step && dir_addr == halt_shown_addr_r |-> ##2 dir_stop_r)
      else $error("address match did not stop");
   a_unread_skip: assert property (
      reg_rd_ack && !reg_rd_readable |=> !ent_valid_r)
      else $error("unreadable register shown");
   a_abort_enter: assert property (
      screen_r == 3'h7 && enter_key |=> load_abort_r)
      else $error("enter did not end load");
   a_halt_arm: assert property (
      cmd_valid && cmd_op == 3'h1 && cmd_has_arg && top
      |-> ##2 halt_shown_r && halt_shown_addr_r == $past(cmd_addr, 2))
      else $error("halt not armed");
   c_stop: cover property (dir_stop_r);
   c_abort: cover property (load_abort_r);
   c_full_page: cover property (ent_valid_r && ent_slot_r == 4'hB);
endmodule
bind maint_console_reg_halt_load console_properties console_properties_inst (.*);
`default_nettype wire

// *** dv/director_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module director_model (
   // clock, reset and bench controls
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic hang,
   input wire logic bad,
   input wire logic go,
   // register port
   input wire logic reg_rd_req_r,
   input wire logic [7:0] reg_rd_name_r,
   output logic reg_rd_ack,
   output logic reg_rd_readable,
   output logic [7:0] reg_rd_data,
   input wire logic reg_wr_r,
   input wire logic [7:0] reg_wr_name_r,
   input wire logic [7:0] reg_wr_data_r,
   // execution
   output logic dir_running,
   output logic dir_step,
   output logic [15:0] dir_addr,
   input wire logic dir_stop_r,
   // microcode_load
   input wire logic load_start_r,
   input wire logic load_abort_r,
   output logic load_done,
   output logic [7:0] load_code
);
   logic [7:0] regs [256];
   logic [7:0] nm;
   logic rdbl;
   int ack_c;
   int ld_c;
   initial begin
      for (int i = 0; i < 256; i++) begin
         regs[i] = 8'(i) ^ 8'h5A;
      end
   end
   // every fourth name unreadable; lines inverted outside an answer
   assign rdbl = nm[1:0] != 2'h3;
   assign reg_rd_readable = reg_rd_ack ? rdbl : !rdbl;
   assign reg_rd_data = reg_rd_ack ? regs[nm] : ~regs[nm];
   assign load_code = bad ? 8'hE1 : 8'hF5;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rd_ack <= 1'h0;
         load_done <= 1'h0;
         dir_running <= 1'h0;
         dir_step <= 1'h0;
         dir_addr <= 16'h0000;
         nm <= 8'h00;
         ack_c <= 0;
         ld_c <= 0;
      end else begin
         reg_rd_ack <= 1'h0;
         load_done <= 1'h0;
         dir_step <= dir_running && !dir_stop_r;
         if (go) begin
            dir_running <= 1'h1;
            dir_addr <= 16'h0000;
         end else if (dir_stop_r) begin
            dir_running <= 1'h0;
         end else if (dir_step) begin
            dir_addr <= dir_addr + 16'h0001;
         end
         if (reg_wr_r) begin
            regs[reg_wr_name_r] <= reg_wr_data_r;
         end
         if (reg_rd_req_r) begin
            nm <= reg_rd_name_r;
            ack_c <= slow ? 4 : 1;
         end else if (ack_c > 0) begin
            ack_c <= ack_c - 1;
            reg_rd_ack <= ack_c == 1;
         end
         if (load_start_r) begin
            ld_c <= 20;
         end else if (load_abort_r) begin
            ld_c <= 0;
         end else if (ld_c > 0 && !hang) begin
            ld_c <= ld_c - 1;
            load_done <= ld_c == 1;
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/maint_console_reg_halt_load_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module maint_console_reg_halt_load_bench;
   typedef struct packed {
      logic fkey;
      logic [2:0] op;
      logic arg;
      logic [2:0] scr;
      logic sh;
   } row_s;
   logic clk, rst_n, cmd_valid, cmd_has_arg, cmd_has_data, enter_key, func_key, other_cmd_done;
   logic [2:0] cmd_op, screen_r;
   logic [7:0] cmd_name, cmd_data, ent_name_r, ent_data_r, load_code_r, reg_rd_name_r;
   logic [7:0] reg_rd_data, reg_wr_name_r, reg_wr_data_r, load_code;
   logic [15:0] cmd_addr, halt_shown_addr_r, dir_addr, wr_seen;
   logic [3:0] ent_slot_r;
   logic halt_shown_r, ent_valid_r, page_done_r, load_ok_r, reg_rd_req_r, reg_rd_ack;
   logic reg_rd_readable, reg_wr_r, dir_running, dir_step, dir_stop_r, load_start_r;
   logic load_abort_r, load_done, slow, hang, bad, go;
   int error_cnt, samples_checked, n;
   row_s rows [7] = '{'{1'h0, 3'h0, 1'h0, 3'h1, 1'h0}, '{1'h1, 3'h0, 1'h0, 3'h0, 1'h0},
      '{1'h0, 3'h0, 1'h0, 3'h1, 1'h0}, '{1'h0, 3'h4, 1'h0, 3'h0, 1'h0},
      '{1'h0, 3'h1, 1'h1, 3'h0, 1'h1}, '{1'h0, 3'h1, 1'h0, 3'h0, 1'h0},
      '{1'h0, 3'h1, 1'h1, 3'h0, 1'h1}};
   maint_console_reg_halt_load #(.REG_COUNT(16)) maint_console_reg_halt_load_inst (.*);
   director_model director_model_inst (.*);
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      if (reg_wr_r === 1'h1) begin
         wr_seen <= {reg_wr_name_r, reg_wr_data_r};
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(input logic [2:0] op, input logic arg, input logic dat,
                       input logic [7:0] nm, input logic [7:0] d);
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_op <= op;
      cmd_has_arg <= arg;
      cmd_has_data <= dat;
      cmd_name <= nm;
      cmd_data <= d;
      @(posedge clk);
      cmd_valid <= 1'h0;
   endtask
   task automatic key(input logic e, input logic f, input logic o);
      @(posedge clk);
      enter_key <= e;
      func_key <= f;
      other_cmd_done <= o;
      @(posedge clk);
      enter_key <= 1'h0;
      func_key <= 1'h0;
      other_cmd_done <= 1'h0;
   endtask
   task automatic wait_scr(input logic [2:0] s);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (screen_r !== s && n < 400);
      chk("screen", s, screen_r);
      if (n == 400) tally_and_finish();
   endtask
   task automatic page(input int want, input logic [7:0] first);
      int cnt;
      cnt = 0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (ent_valid_r === 1'h1) begin
            if (cnt == 0) chk("first name", first, ent_name_r);
            chk("slot", cnt, ent_slot_r);
            chk("readable", 0, ent_name_r[1:0] == 2'h3);
            chk("data", wr_seen[15:8] == ent_name_r ? wr_seen[7:0] : ent_name_r ^ 8'h5A,
                ent_data_r);
            cnt++;
         end
      end while (page_done_r !== 1'h1 && n < 400);
      chk("entries", want, cnt);
      if (n == 400) tally_and_finish();
   endtask
   initial begin
      {rst_n, cmd_valid, cmd_has_arg, cmd_has_data, enter_key, func_key} = 6'h00;
      {other_cmd_done, slow, hang, bad, go} = 5'h00;
      {cmd_op, cmd_name, cmd_data} = 19'h00000;
      cmd_addr = 16'h0010;
      wr_seen = 16'hFFFF;
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].fkey) begin
            key(1'h0, 1'h1, 1'h0);
         end else begin
            send(rows[i].op, rows[i].arg, 1'h0, 8'h00, 8'h00);
         end
         repeat (3) @(negedge clk);
         chk("screen", rows[i].scr, screen_r);
         chk("halt shown", rows[i].sh, halt_shown_r);
         chk("halt addr", rows[i].sh ? 16'h0010 : 16'h0000, halt_shown_addr_r);
      end
      $display("test rows done");
      send(3'h0, 1'h0, 1'h0, 8'h00, 8'h00);
      key(1'h1, 1'h0, 1'h0);
      page(12, 8'h00);
      send(3'h3, 1'h1, 1'h1, 8'h05, 8'hA7);
      page(1, 8'h05);
      chk("write", 16'h05A7, wr_seen);
      slow <= 1'h1;
      key(1'h1, 1'h0, 1'h0);
      page(12, 8'h06);
      slow <= 1'h0;
      key(1'h0, 1'h1, 1'h0);
      wait_scr(3'h0);
      $display("test pages done");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         go <= 1'h1;
         @(posedge clk);
         go <= 1'h0;
         key(1'h0, 1'h0, 1'h1);
         wait_scr(3'h6);
         if (k == 1) key(1'h1, 1'h0, 1'h0);
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (dir_stop_r !== 1'h1 && n < 100);
         chk("stop", 1'h1, dir_stop_r);
         if (n == 100) tally_and_finish();
         wait_scr(3'h0);
         chk("halt addr", 16'h0010, halt_shown_addr_r);
      end
      $display("test halt done");
      for (int k = 0; k < 3; k++) begin
         bad <= k > 0;
         hang <= k == 2;
         send(3'h2, 1'h0, 1'h0, 8'h00, 8'h00);
         wait_scr(3'h7);
         repeat (k == 2 ? 40 : 0) @(negedge clk);
         if (k == 2) chk("hung", 3'h7, screen_r);
         if (k == 2) key(1'h1, 1'h0, 1'h0);
         wait_scr(3'h5);
         chk("code", k == 0 ? 16'h00F5 : 16'h00E1, load_code_r);
         chk("normal", k == 0, load_ok_r);
         repeat (5) @(negedge clk);
         chk("code held", 3'h5, screen_r);
         key(k == 0, k != 0, 1'h0);
         wait_scr(3'h0);
      end
      hang <= 1'h0;
      $display("test load done");
      send(3'h0, 1'h0, 1'h0, 8'h00, 8'h00);
      wait_scr(3'h1);
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (2) @(negedge clk);
      chk("reset screen", 3'h0, screen_r);
      chk("reset halt", 1'h0, halt_shown_r);
      @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      send(3'h0, 1'h0, 1'h0, 8'h00, 8'h00);
      wait_scr(3'h1);
      $display("test reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** rtl/addr_halt.sv ***
`timescale 1ns/1ns
`default_nettype none
module addr_halt (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic arm,
   input wire logic disarm,
   input wire logic [console_pkg::ADDR_W-1:0] arm_addr,
   // director
   input wire logic dir_step,
   input wire logic [console_pkg::ADDR_W-1:0] dir_addr,
   // state
   output logic armed_r,
   output logic [console_pkg::ADDR_W-1:0] halt_addr_r,
   output logic stop_r
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
         halt_addr_r <= '0;
      end else if (arm) begin
         armed_r <= 1'b1; // RULE_07
         halt_addr_r <= arm_addr;
      end else if (disarm) begin
         armed_r <= 1'b0; // RULE_08
         halt_addr_r <= '0;
      end
   end

   // compare on every step while armed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stop_r <= 1'b0;
      end else begin
         stop_r <= armed_r && dir_step && (dir_addr == halt_addr_r); // RULE_17
      end
   end

endmodule
`default_nettype wire

// *** rtl/console_pkg.sv ***
// Notes on behaviour
// RULE_01: name shows register; name plus data writes, shows
// RULE_02: register pages hold twelve registers
// RULE_03: unreadable registers are skipped in pages
// RULE_04: bare enter shows next register page
// RULE_05: function key ends register command
// RULE_06: invalid subcommand returns to status screen
// RULE_07: halt with address arms compare halt
// RULE_08: halt without address disarms, clears shown address
// RULE_09: armed and running after command: waiting message
// RULE_10: waiting ends on address match or enter
// RULE_11: status screen shows armed halt address
// RULE_12: load starts microcode load, shows progress
// RULE_13: completion code shown until enter or function key
// RULE_14: operator presses no key during load
// RULE_15: enter terminates a hung load
// RULE_16: completion code F5 means normal end
// RULE_17: armed address compared each step; match stops
package console_pkg;

   localparam int NAME_W = 8;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 16;
   localparam int CODE_W = 8;
   localparam int SLOT_W = 4;

   localparam logic [SLOT_W-1:0] PAGE_REGS = 4'hC;
   localparam logic [SLOT_W-1:0] ONE_REG = 4'h1;
   localparam logic [CODE_W-1:0] LOAD_CODE_OK = 8'hF5;
   localparam logic [NAME_W-1:0] FIRST_NAME = 8'h00;

   typedef enum logic [2:0] {
      OP_EXT = 3'h0,
      OP_HALT = 3'h1,
      OP_LOAD = 3'h2,
      OP_SUB = 3'h3,
      OP_BAD = 3'h4
   } op_e;

   // screen codes, gray along the usual path
   typedef enum logic [2:0] {
      SCR_STATUS = 3'h0,
      SCR_EXT_PROMPT = 3'h1,
      SCR_EXT_BUSY = 3'h3,
      SCR_EXT_SHOW = 3'h2,
      SCR_WAIT_HALT = 3'h6,
      SCR_LOAD_RUN = 3'h7,
      SCR_LOAD_DONE = 3'h5
   } screen_e;

   typedef enum logic [1:0] {
      SC_IDLE = 2'h0,
      SC_ASK = 2'h1,
      SC_WAIT = 2'h3
   } scan_e;

endpackage

// *** rtl/maint_console_reg_halt_load.sv ***
`timescale 1ns/1ns
`default_nettype none
module maint_console_reg_halt_load #(
   parameter int REG_COUNT = 256
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // parsed console input
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic cmd_has_arg,
   input wire logic cmd_has_data,
   input wire logic [console_pkg::NAME_W-1:0] cmd_name,
   input wire logic [console_pkg::DATA_W-1:0] cmd_data,
   input wire logic [console_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic enter_key,
   input wire logic func_key,
   input wire logic other_cmd_done,
   // screen
   output logic [2:0] screen_r,
   output logic halt_shown_r,
   output logic [console_pkg::ADDR_W-1:0] halt_shown_addr_r,
   output logic ent_valid_r,
   output logic [console_pkg::SLOT_W-1:0] ent_slot_r,
   output logic [console_pkg::NAME_W-1:0] ent_name_r,
   output logic [console_pkg::DATA_W-1:0] ent_data_r,
   output logic page_done_r,
   output logic [console_pkg::CODE_W-1:0] load_code_r,
   output logic load_ok_r,
   // director external registers
   output logic reg_rd_req_r,
   output logic [console_pkg::NAME_W-1:0] reg_rd_name_r,
   input wire logic reg_rd_ack,
   input wire logic reg_rd_readable,
   input wire logic [console_pkg::DATA_W-1:0] reg_rd_data,
   output logic reg_wr_r,
   output logic [console_pkg::NAME_W-1:0] reg_wr_name_r,
   output logic [console_pkg::DATA_W-1:0] reg_wr_data_r,
   // director execution
   input wire logic dir_running,
   input wire logic dir_step,
   input wire logic [console_pkg::ADDR_W-1:0] dir_addr,
   output logic dir_stop_r,
   // target_director microcode_load
   output logic load_start_r,
   output logic load_abort_r,
   input wire logic load_done,
   input wire logic [console_pkg::CODE_W-1:0] load_code
);
   logic rst_meta_r;
   logic rst_sync_r;
   console_pkg::screen_e state_r;
   logic is_cmd;
   logic is_sub;
   logic scan_start;
   logic [console_pkg::NAME_W-1:0] scan_name;
   logic [console_pkg::SLOT_W-1:0] scan_limit;
   logic scan_busy;
   logic scan_done;
   logic [console_pkg::NAME_W-1:0] scan_next;
   logic [console_pkg::NAME_W-1:0] page_name_r;
   logic wr_pending_r;
   logic halt_arm;
   logic halt_disarm;
   logic halt_armed;
   logic [console_pkg::ADDR_W-1:0] halt_addr;
   logic halt_stop;

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   function automatic logic op_is(input logic [2:0] op, input console_pkg::op_e want);
      op_is = (op == 3'(want));
   endfunction

   assign is_cmd = cmd_valid && state_r == console_pkg::SCR_STATUS;
   assign is_sub = cmd_valid && op_is(cmd_op, console_pkg::OP_SUB) && cmd_has_arg;
   assign halt_arm = is_cmd && op_is(cmd_op, console_pkg::OP_HALT) && cmd_has_arg;
   assign halt_disarm = is_cmd && op_is(cmd_op, console_pkg::OP_HALT) && !cmd_has_arg;

   addr_halt u_halt (
      .clk(clk),
      .rst_n(rst_sync_r),
      .arm(halt_arm),
      .disarm(halt_disarm),
      .arm_addr(cmd_addr),
      .dir_step(dir_step),
      .dir_addr(dir_addr),
      .armed_r(halt_armed),
      .halt_addr_r(halt_addr),
      .stop_r(halt_stop)
   );

   // scan requests: a named register alone, or the next page
   always_comb begin
      scan_start = 1'b0;
      scan_name = page_name_r;
      scan_limit = console_pkg::PAGE_REGS; // RULE_02
      if (wr_pending_r) begin
         scan_start = 1'b1;
         scan_name = reg_wr_name_r;
         scan_limit = console_pkg::ONE_REG;
      end else if ((state_r == console_pkg::SCR_EXT_PROMPT
                    || state_r == console_pkg::SCR_EXT_SHOW) && !scan_busy) begin
         if (is_sub && !cmd_has_data) begin
            scan_start = 1'b1; // RULE_01
            scan_name = cmd_name;
            scan_limit = console_pkg::ONE_REG;
         end else if (enter_key && !cmd_valid) begin
            scan_start = 1'b1; // RULE_04
         end
      end
   end

   reg_page_scan #(
      .REG_COUNT(REG_COUNT)
   ) u_scan (
      .clk(clk),
      .rst_n(rst_sync_r),
      .start(scan_start),
      .start_name(scan_name),
      .limit(scan_limit),
      .busy_r(scan_busy),
      .done_r(scan_done),
      .next_name_r(scan_next),
      .rd_req_r(reg_rd_req_r),
      .rd_name_r(reg_rd_name_r),
      .rd_ack(reg_rd_ack),
      .rd_readable(reg_rd_readable),
      .rd_data(reg_rd_data),
      .ent_valid_r(ent_valid_r),
      .ent_slot_r(ent_slot_r),
      .ent_name_r(ent_name_r),
      .ent_data_r(ent_data_r)
   );

   // console screen sequencing
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= console_pkg::SCR_STATUS;
      end else begin
         unique case (state_r)
            console_pkg::SCR_STATUS: begin
               if (is_cmd && op_is(cmd_op, console_pkg::OP_EXT)) begin
                  state_r <= console_pkg::SCR_EXT_PROMPT;
               end else if (is_cmd && op_is(cmd_op, console_pkg::OP_LOAD)) begin
                  state_r <= console_pkg::SCR_LOAD_RUN; // RULE_12
               end else if (other_cmd_done && halt_armed && dir_running) begin
                  state_r <= console_pkg::SCR_WAIT_HALT; // RULE_09
               end
            end
            console_pkg::SCR_EXT_PROMPT, console_pkg::SCR_EXT_SHOW: begin
               if (func_key) begin
                  state_r <= console_pkg::SCR_STATUS; // RULE_05
               end else if (cmd_valid && !is_sub) begin
                  state_r <= console_pkg::SCR_STATUS; // RULE_06
               end else if (scan_start || (is_sub && cmd_has_data)) begin
                  state_r <= console_pkg::SCR_EXT_BUSY;
               end
            end
            console_pkg::SCR_EXT_BUSY: begin
               if (func_key) begin
                  state_r <= console_pkg::SCR_STATUS; // RULE_05
               end else if (scan_done) begin
                  state_r <= console_pkg::SCR_EXT_SHOW;
               end
            end
            console_pkg::SCR_WAIT_HALT: begin
               if (halt_stop || enter_key) begin
                  state_r <= console_pkg::SCR_STATUS; // RULE_10
               end
            end
            console_pkg::SCR_LOAD_RUN: begin
               // other keys are the operator's to avoid
               if (load_done || enter_key) begin
                  state_r <= console_pkg::SCR_LOAD_DONE; // RULE_15
               end
            end
            console_pkg::SCR_LOAD_DONE: begin
               if (enter_key || func_key) begin
                  state_r <= console_pkg::SCR_STATUS; // RULE_13
               end
            end
            default: state_r <= console_pkg::SCR_STATUS;
         endcase
      end
   end

   assign screen_r = state_r;

   // page position and completion marker
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         page_name_r <= console_pkg::FIRST_NAME;
         page_done_r <= 1'b0;
      end else begin
         page_done_r <= scan_done;
         if (is_cmd && op_is(cmd_op, console_pkg::OP_EXT)) begin
            page_name_r <= console_pkg::FIRST_NAME;
         end else if (scan_done) begin
            page_name_r <= scan_next; // RULE_04
         end
      end
   end

   // write then show the altered register
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         reg_wr_r <= 1'b0;
         reg_wr_name_r <= '0;
         reg_wr_data_r <= '0;
         wr_pending_r <= 1'b0;
      end else begin
         reg_wr_r <= 1'b0;
         wr_pending_r <= reg_wr_r;
         if ((state_r == console_pkg::SCR_EXT_PROMPT || state_r == console_pkg::SCR_EXT_SHOW)
             && !func_key && is_sub && cmd_has_data && !scan_busy) begin
            reg_wr_r <= 1'b1; // RULE_01
            reg_wr_name_r <= cmd_name;
            reg_wr_data_r <= cmd_data;
         end
      end
   end

   // halt address on the status screen
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         halt_shown_r <= 1'b0;
         halt_shown_addr_r <= '0;
         dir_stop_r <= 1'b0;
      end else begin
         halt_shown_r <= halt_armed; // RULE_11
         halt_shown_addr_r <= halt_addr;
         dir_stop_r <= halt_stop; // RULE_17
      end
   end

   // microcode_load control and completion code
   always_ff @(posedge clk or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         load_start_r <= 1'b0;
         load_abort_r <= 1'b0;
         load_code_r <= '0;
         load_ok_r <= 1'b0;
      end else begin
         load_start_r <= is_cmd && op_is(cmd_op, console_pkg::OP_LOAD); // RULE_12
         load_abort_r <= 1'b0;
         if (state_r == console_pkg::SCR_LOAD_RUN) begin
            if (load_done) begin
               load_code_r <= load_code; // RULE_13
               load_ok_r <= (load_code == console_pkg::LOAD_CODE_OK); // RULE_16
            end else if (enter_key) begin
               load_abort_r <= 1'b1; // RULE_15
               load_code_r <= load_code;
               load_ok_r <= (load_code == console_pkg::LOAD_CODE_OK);
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/reg_page_scan.sv ***
`timescale 1ns/1ns
`default_nettype none
module reg_page_scan #(
   parameter int REG_COUNT = 256
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [console_pkg::NAME_W-1:0] start_name,
   input wire logic [console_pkg::SLOT_W-1:0] limit,
   output logic busy_r,
   output logic done_r,
   output logic [console_pkg::NAME_W-1:0] next_name_r,
   // register read port
   output logic rd_req_r,
   output logic [console_pkg::NAME_W-1:0] rd_name_r,
   input wire logic rd_ack,
   input wire logic rd_readable,
   input wire logic [console_pkg::DATA_W-1:0] rd_data,
   // entries
   output logic ent_valid_r,
   output logic [console_pkg::SLOT_W-1:0] ent_slot_r,
   output logic [console_pkg::NAME_W-1:0] ent_name_r,
   output logic [console_pkg::DATA_W-1:0] ent_data_r
);
   localparam logic [15:0] SCAN_MAX = 16'(REG_COUNT);

   console_pkg::scan_e state_r;
   logic [console_pkg::SLOT_W-1:0] slot_r;
   logic [console_pkg::SLOT_W-1:0] limit_r;
   logic [15:0] scanned_r;
   logic [console_pkg::SLOT_W-1:0] slot_nxt;
   logic [15:0] scanned_nxt;

   assign slot_nxt = rd_readable ? slot_r + 4'h1 : slot_r;
   assign scanned_nxt = scanned_r + 16'h0001;
   assign busy_r = (state_r != console_pkg::SC_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= console_pkg::SC_IDLE;
         slot_r <= '0;
         limit_r <= '0;
         scanned_r <= '0;
         rd_name_r <= console_pkg::FIRST_NAME;
         next_name_r <= console_pkg::FIRST_NAME;
         rd_req_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         rd_req_r <= 1'b0;
         done_r <= 1'b0;
         unique case (state_r)
            console_pkg::SC_IDLE: begin
               if (start) begin
                  rd_name_r <= start_name;
                  limit_r <= limit;
                  slot_r <= '0;
                  scanned_r <= '0;
                  state_r <= console_pkg::SC_ASK;
               end
            end
            console_pkg::SC_ASK: begin
               rd_req_r <= 1'b1;
               state_r <= console_pkg::SC_WAIT;
            end
            console_pkg::SC_WAIT: begin
               if (rd_ack) begin
                  slot_r <= slot_nxt;
                  scanned_r <= scanned_nxt;
                  rd_name_r <= rd_name_r + 8'h01;
                  if (slot_nxt == limit_r || scanned_nxt == SCAN_MAX) begin
                     next_name_r <= rd_name_r + 8'h01;
                     done_r <= 1'b1;
                     state_r <= console_pkg::SC_IDLE;
                  end else begin
                     state_r <= console_pkg::SC_ASK;
                  end
               end
            end
            default: state_r <= console_pkg::SC_IDLE;
         endcase
      end
   end

   // only readable registers become entries
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ent_valid_r <= 1'b0;
         ent_slot_r <= '0;
         ent_name_r <= '0;
         ent_data_r <= '0;
      end else begin
         ent_valid_r <= 1'b0;
         if (state_r == console_pkg::SC_WAIT && rd_ack && rd_readable) begin // RULE_03
            ent_valid_r <= 1'b1;
            ent_slot_r <= slot_r;
            ent_name_r <= rd_name_r;
            ent_data_r <= rd_data;
         end
      end
   end

endmodule
`default_nettype wire
